// File: rtl/pfi_cfg.svh
// constants of the pll fabric interface model
// assumes: included by the package and the top module, after nothing else
//
// Behaviour
// - internal feedback: output rate is ref times M over N times O times C.
// - local/core feedback: output rate is ref times M times C0 over N times C.
// - detector rate is ref over N; post-divider rate is oscillator over O.
// - two-bit select picks one of four reference inputs, changeable at run time.
// - pll is held in reset while its active-low reset is low.
// - lock rises on achieving lock and falls on loss of lock.
// - lock keeps its level when the selected reference stops toggling.
// - three output clocks are provided for the global clock network.
// - reference source is pad, core clock, or dynamic among four inputs.
// - phase shift allowed only with C of 2, 4 or 6 as listed.
`ifndef PFI_CFG_SVH
`define PFI_CFG_SVH

// -----------------------------------------------------------------
// widths and limits
// -----------------------------------------------------------------
`define PFI_PER_W        16
`define PFI_ACC_W        34
`define PFI_NUM_W        20
`define PFI_DEN_W        16
`define PFI_STALL_CYCLES 16'hffff
`define PFI_PERIOD_TOL   16'h0001
`define PFI_LOCK_EDGES   4'h8
`define PFI_MOC_LIMIT    20'h000ff
`define PFI_PAD_INPUT    2'h0
`define PFI_CORE_INPUT   2'h1

// -----------------------------------------------------------------
// phase codes and divider values that permit them
// -----------------------------------------------------------------
`define PFI_PH_0         3'h0
`define PFI_PH_45        3'h1
`define PFI_PH_90        3'h2
`define PFI_PH_135       3'h3
`define PFI_PH_180       3'h4
`define PFI_PH_270       3'h5
`define PFI_Q_270        3'h6
`define PFI_DIV_2        9'h002
`define PFI_DIV_4        9'h004
`define PFI_DIV_6        9'h006

`endif

// File: rtl/pfi_pkg.sv
// types shared by the pll fabric interface model
// assumes: pfi_cfg.svh is on the include path
`include "pfi_cfg.svh"

package pfi_pkg;

  typedef enum logic [1:0] {
    PFI_FB_INTERNAL = 2'h0,
    PFI_FB_LOCAL    = 2'h1,
    PFI_FB_CORE     = 2'h2
  } pfi_fb_t;

  typedef enum logic [1:0] {
    PFI_SRC_PAD     = 2'h0,
    PFI_SRC_CORE    = 2'h1,
    PFI_SRC_DYNAMIC = 2'h2
  } pfi_src_t;

  typedef struct packed {
    logic [7:0] mult;
    logic [3:0] prediv;
    logic [3:0] postdiv;
    logic [8:0] div0;
    logic [8:0] div1;
    logic [8:0] div2;
    logic [2:0] phase0;
    logic [2:0] phase1;
    logic [2:0] phase2;
    logic [2:0] out_en;
    pfi_fb_t    fb_mode;
    pfi_src_t   src_mode;
  } pfi_settings_t;

endpackage : pfi_pkg

// File: rtl/pfi_top.sv
// cycle-level model of a pll as seen from the fabric: reference select,
// pll reset, lock and three synthesized output clocks
// assumes: CORE_CLK well above every reference and output rate; settings
// and pll reset come from logic on CORE_CLK; reference and feedback are pins
`timescale 1ns/1ps
`include "pfi_cfg.svh"

module pfi_top
  import pfi_pkg::*;
(
  // clock and reset
  input  wire logic          CORE_CLK,
  input  wire logic          RESETN,
  // reference and feedback pins
  input  wire logic [3:0]    REFERENCE_CLOCK_INPUTS,
  input  wire logic          FABRIC_FEEDBACK_CLOCK,
  // user control
  input  wire logic [1:0]    REFERENCE_SELECT,
  input  wire logic          PLL_RESET_LOW,
  input  wire pfi_settings_t PLL_SETTINGS,
  // clocks and status
  output logic               OUTPUT_CLOCK_ZERO,
  output logic               OUTPUT_CLOCK_ONE,
  output logic               OUTPUT_CLOCK_TWO,
  output logic               PFD_CLOCK,
  output logic               POST_DIVIDER_CLOCK,
  output logic               LOCKED,
  output logic               SETTING_ERROR
);

  // -----------------------------------------------------------------
  // decoding helpers
  // -----------------------------------------------------------------
  // quarter-half-period steps for a phase code, zero if the divider forbids it
  function automatic logic [2:0] phase_q(input logic [2:0] code, input logic [8:0] div);
    logic [2:0] q;
    q = `PFI_PH_0;
    case (code)
      `PFI_PH_45:  q = (div == `PFI_DIV_4) ? `PFI_PH_45 : `PFI_PH_0;
      `PFI_PH_90:  q = (div == `PFI_DIV_2 || div == `PFI_DIV_4 || div == `PFI_DIV_6) ? `PFI_PH_90 : `PFI_PH_0;
      `PFI_PH_135: q = (div == `PFI_DIV_4) ? `PFI_PH_135 : `PFI_PH_0;
      `PFI_PH_180: q = (div == `PFI_DIV_2) ? `PFI_PH_180 : `PFI_PH_0;
      `PFI_PH_270: q = (div == `PFI_DIV_2) ? `PFI_Q_270 : `PFI_PH_0;
      default:     q = `PFI_PH_0;
    endcase
    return q;
  endfunction : phase_q

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [3:0] ref_s1_reg;
  logic [3:0] ref_s2_reg;
  logic       fb_s1_reg;
  logic       fb_s2_reg;
  logic       fb_prev_reg;
  logic       ref_prev_reg;
  logic       ref_now;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ref_s1_reg   <= 4'h0;
      ref_s2_reg   <= 4'h0;
      fb_s1_reg    <= 1'b0;
      fb_s2_reg    <= 1'b0;
      fb_prev_reg  <= 1'b0;
      ref_prev_reg <= 1'b0;
    end else begin
      ref_s1_reg   <= REFERENCE_CLOCK_INPUTS;
      ref_s2_reg   <= ref_s1_reg;
      fb_s1_reg    <= FABRIC_FEEDBACK_CLOCK;
      fb_s2_reg    <= fb_s1_reg;
      fb_prev_reg  <= fb_s2_reg;
      ref_prev_reg <= ref_now;
    end
  end

  // -----------------------------------------------------------------
  // reference source and settings check
  // -----------------------------------------------------------------
  logic [1:0]            src_idx;
  logic                  ref_edge;
  logic                  fb_edge;
  logic [`PFI_NUM_W-1:0] moc;
  logic [1:0]            en_count;
  logic                  cfg_err;
  logic                  run;

  // a select change under a running pll would glitch the period measure
  assign src_idx  = (PLL_SETTINGS.src_mode == PFI_SRC_DYNAMIC) ? REFERENCE_SELECT :
                    (PLL_SETTINGS.src_mode == PFI_SRC_CORE) ? `PFI_CORE_INPUT : `PFI_PAD_INPUT;
  assign ref_now  = ref_s2_reg[src_idx];
  assign ref_edge = ref_now & ~ref_prev_reg;
  assign fb_edge  = fb_s2_reg & ~fb_prev_reg;

  assign moc      = `PFI_NUM_W'(PLL_SETTINGS.mult * PLL_SETTINGS.postdiv * PLL_SETTINGS.div0);
  assign en_count = 2'(PLL_SETTINGS.out_en[0] + PLL_SETTINGS.out_en[1] + PLL_SETTINGS.out_en[2]);
  // bad settings keep the loop in reset instead of producing wrong clocks
  assign cfg_err  = (PLL_SETTINGS.fb_mode != PFI_FB_INTERNAL && moc > `PFI_MOC_LIMIT)
                  || !(PLL_SETTINGS.postdiv inside {4'h1, 4'h2, 4'h4, 4'h8})
                  || (PLL_SETTINGS.postdiv == 4'h1 && en_count > 2'h1)
                  || PLL_SETTINGS.mult == 8'h00 || PLL_SETTINGS.prediv == 4'h0
                  || PLL_SETTINGS.div0 == 9'h000 || PLL_SETTINGS.div1 == 9'h000
                  || PLL_SETTINGS.div2 == 9'h000 || PLL_SETTINGS.fb_mode == 2'h3;
  assign run      = PLL_RESET_LOW & ~cfg_err;

  // -----------------------------------------------------------------
  // period measure and lock detect
  // -----------------------------------------------------------------
  logic [`PFI_PER_W-1:0] gap_reg;
  logic [`PFI_PER_W-1:0] period_reg;
  logic [3:0]            stable_reg;
  logic                  fb_seen_reg;
  logic                  lock_reg;
  logic                  lock_next;
  logic                  stalled;
  logic                  period_match;
  logic [`PFI_PER_W-1:0] gap_len;

  assign stalled      = (gap_reg == `PFI_STALL_CYCLES);
  assign gap_len      = gap_reg + `PFI_PER_W'(1);
  assign period_match = (gap_len >= period_reg - `PFI_PERIOD_TOL) && (gap_len <= period_reg + `PFI_PERIOD_TOL);
  assign lock_next    = !run                                              ? 1'b0 :
                        stalled                                           ? lock_reg :
                        (ref_edge && !period_match)                       ? 1'b0 :
                        (stable_reg == `PFI_LOCK_EDGES &&
                         (PLL_SETTINGS.fb_mode != PFI_FB_CORE || fb_seen_reg)) ? 1'b1 :
                        lock_reg;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      gap_reg     <= 16'h0000;
      period_reg  <= 16'h0000;
      stable_reg  <= 4'h0;
      fb_seen_reg <= 1'b0;
      lock_reg    <= 1'b0;
    end else begin
      lock_reg    <= lock_next;
      fb_seen_reg <= run & (fb_seen_reg | fb_edge);
      if (ref_edge) begin
        gap_reg    <= 16'h0000;
        period_reg <= gap_len;
      end else if (!stalled) begin
        gap_reg <= gap_len;
      end
      if (!run || (ref_edge && !period_match)) begin
        stable_reg <= 4'h0;
      end else if (ref_edge && stable_reg != `PFI_LOCK_EDGES) begin
        stable_reg <= stable_reg + 4'h1;
      end
    end
  end

  // -----------------------------------------------------------------
  // clock synthesis: 0..2 outputs, 3 detector, 4 post-divider
  // -----------------------------------------------------------------
  // each channel toggles when its accumulator passes period*den, so its rate
  // is num/(period*den) of the core rate, or 1/(period*den) for the detector; above half the core rate it saturates
  logic [`PFI_NUM_W-1:0] num;
  logic [`PFI_DEN_W-1:0] loop_den;
  logic [`PFI_DEN_W-1:0] den  [5];
  logic [8:0]            divs [3];
  logic [2:0]            q    [5];
  logic [4:0]            en;
  logic [4:0]            clk_reg;
  logic                  fb_prime;

  assign num      = (PLL_SETTINGS.fb_mode == PFI_FB_INTERNAL) ? `PFI_NUM_W'(PLL_SETTINGS.mult) :
                    `PFI_NUM_W'(PLL_SETTINGS.mult * PLL_SETTINGS.div0);
  assign loop_den = (PLL_SETTINGS.fb_mode == PFI_FB_INTERNAL) ?
                    `PFI_DEN_W'(PLL_SETTINGS.prediv * PLL_SETTINGS.postdiv) : `PFI_DEN_W'(PLL_SETTINGS.prediv);
  assign divs[0]  = PLL_SETTINGS.div0;
  assign divs[1]  = PLL_SETTINGS.div1;
  assign divs[2]  = PLL_SETTINGS.div2;
  assign q[0]     = phase_q(PLL_SETTINGS.phase0, PLL_SETTINGS.div0);
  assign q[1]     = phase_q(PLL_SETTINGS.phase1, PLL_SETTINGS.div1);
  assign q[2]     = phase_q(PLL_SETTINGS.phase2, PLL_SETTINGS.div2);
  assign q[3]     = `PFI_PH_0;
  assign q[4]     = `PFI_PH_0;
  assign den[3]   = `PFI_DEN_W'(PLL_SETTINGS.prediv);
  assign den[4]   = loop_den;
  assign en       = {2'b11, PLL_SETTINGS.out_en};
  // core feedback: output zero runs once the period settles, else the loop never closes;
  // only output zero is primed, so the fabric must feed back that one
  assign fb_prime = (PLL_SETTINGS.fb_mode == PFI_FB_CORE) && (stable_reg == `PFI_LOCK_EDGES);

  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_den
      assign den[k] = `PFI_DEN_W'(loop_den * divs[k]);
    end
    for (k = 0; k < 5; k++) begin : g_chan
      logic [`PFI_ACC_W-1:0] acc_reg;
      logic [`PFI_ACC_W-1:0] acc_sum;
      logic [`PFI_ACC_W-1:0] thr;
      logic [`PFI_ACC_W-1:0] offset;
      logic [`PFI_NUM_W:0]   inc;
      logic                  active;

      assign inc    = (k == 3) ? (`PFI_NUM_W+1)'(2) : {num, 1'b0};
      assign thr    = `PFI_ACC_W'(period_reg * den[k]);
      assign offset = `PFI_ACC_W'((thr >> 2) * q[k]);
      assign acc_sum = acc_reg + `PFI_ACC_W'(inc);
      assign active = run & en[k] & (lock_reg | ((k == 0) & fb_prime));

      always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
          acc_reg    <= 34'h0;
          clk_reg[k] <= 1'b0;
        end else if (!active) begin
          acc_reg    <= offset;
          clk_reg[k] <= 1'b0;
        end else if (acc_sum >= thr) begin
          acc_reg    <= acc_sum - thr;
          clk_reg[k] <= ~clk_reg[k];
        end else begin
          acc_reg <= acc_sum;
        end
      end
    end
  endgenerate

  logic err_reg;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= cfg_err;
    end
  end

  assign OUTPUT_CLOCK_ZERO  = clk_reg[0];
  assign OUTPUT_CLOCK_ONE   = clk_reg[1];
  assign OUTPUT_CLOCK_TWO   = clk_reg[2];
  assign PFD_CLOCK          = clk_reg[3];
  assign POST_DIVIDER_CLOCK = clk_reg[4];
  assign LOCKED             = lock_reg;
  assign SETTING_ERROR      = err_reg;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  a_reset_clears_lock: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !PLL_RESET_LOW |=> !LOCKED) else $error("lock high after pll reset");
  a_reset_stops_clocks: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !PLL_RESET_LOW |=> !LOCKED ##1 (!OUTPUT_CLOCK_ZERO && !OUTPUT_CLOCK_ONE && !OUTPUT_CLOCK_TWO))
    else $error("output clock running in pll reset");
  a_lock_needs_edges: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    $rose(LOCKED) |-> $past(stable_reg) == `PFI_LOCK_EDGES) else $error("lock without stable edges");
  a_lock_loss_drop: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    LOCKED && ref_edge && !period_match && !stalled |=> !LOCKED) else $error("lock kept after loss");
  a_stall_holds_lock: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    run && stalled |=> $stable(LOCKED)) else $error("lock moved on stopped reference");
  a_dynamic_select: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    PLL_SETTINGS.src_mode == PFI_SRC_DYNAMIC |-> src_idx == REFERENCE_SELECT) else $error("wrong source");
  a_phase_filter: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    PLL_SETTINGS.div1 != `PFI_DIV_4 && PLL_SETTINGS.phase1 == `PFI_PH_45 |-> q[1] == `PFI_PH_0)
    else $error("forbidden phase accepted");
  a_core_fb_gate: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    PLL_SETTINGS.fb_mode == PFI_FB_CORE && !fb_seen_reg && !LOCKED |=> !LOCKED)
    else $error("core feedback lock without feedback");
  a_setting_limit: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    PLL_SETTINGS.fb_mode == PFI_FB_LOCAL && moc > `PFI_MOC_LIMIT |=> SETTING_ERROR && !LOCKED)
    else $error("oversized feedback product not flagged");

endmodule : pfi_top

// File: test/pfi_user_model.sv
// fabric-side user logic model: four reference clocks and the feedback route
// assumes: clocked by the bench's CORE_CLK; references move only on its edges
`timescale 1ns/1ps

module pfi_user_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // stimulus control
  input  wire logic       stop,
  input  wire logic [7:0] stretch,
  // pll side
  input  wire logic       out_zero,
  output logic      [3:0] ref_clks,
  output logic            fb_clk
);
  logic [7:0] cnt_reg [4];

  // input k has a period of 32+8k cycles plus twice stretch; stop freezes them like a dead pad
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_clks <= 4'h0;
      for (int k = 0; k < 4; k++) cnt_reg[k] <= 8'h00;
    end else if (!stop) begin
      for (int k = 0; k < 4; k++) begin
        if (cnt_reg[k] >= 8'(15 + 4 * k) + stretch) begin
          cnt_reg[k]  <= 8'h00;
          ref_clks[k] <= ~ref_clks[k];
        end else begin
          cnt_reg[k] <= cnt_reg[k] + 8'h01;
        end
      end
    end
  end

  // core feedback is taken from output zero, as the fabric would route it
  assign fb_clk = out_zero;
endmodule : pfi_user_model

// File: test/tb_pll_fabric_interface.sv
// self-checking bench of the pll fabric interface model
// assumes: pfi_pkg compiled first; inputs driven on the falling edge
`timescale 1ns/1ps

module tb_pll_fabric_interface;
  import pfi_pkg::*;
  logic          CORE_CLK;
  logic          RESETN;
  logic          PLL_RESET_LOW;
  logic [1:0]    REFERENCE_SELECT;
  pfi_settings_t PLL_SETTINGS;
  logic          stop;
  logic [7:0]    stretch;
  logic [2:0]    phase_one;
  logic [3:0]    ref_clks;
  logic          fb_clk;
  logic [4:0]    clks;
  logic          LOCKED;
  logic          SETTING_ERROR;
  int            n_errors;
  int            checked;

  pfi_top i_pfi_top (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .REFERENCE_CLOCK_INPUTS(ref_clks),
    .FABRIC_FEEDBACK_CLOCK(fb_clk), .REFERENCE_SELECT(REFERENCE_SELECT), .PLL_RESET_LOW(PLL_RESET_LOW),
    .PLL_SETTINGS(PLL_SETTINGS), .OUTPUT_CLOCK_ZERO(clks[0]), .OUTPUT_CLOCK_ONE(clks[1]),
    .OUTPUT_CLOCK_TWO(clks[2]), .PFD_CLOCK(clks[3]), .POST_DIVIDER_CLOCK(clks[4]), .LOCKED(LOCKED),
    .SETTING_ERROR(SETTING_ERROR));

  pfi_user_model i_pfi_user_model (.clk(CORE_CLK), .rst_n(RESETN), .stop(stop), .stretch(stretch),
    .out_zero(clks[0]), .ref_clks(ref_clks), .fb_clk(fb_clk));

  always #10 CORE_CLK = ~CORE_CLK;

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // settings only change with the pll held in reset, for three cycles
  task automatic apply(pfi_fb_t fb, pfi_src_t src, logic [1:0] sel, logic [7:0] m, logic [3:0] n,
                       logic [3:0] o, logic [8:0] c0, logic [8:0] c1, logic [8:0] c2);
    pfi_settings_t s;
    s = '0;
    s.fb_mode = fb;
    s.src_mode = src;
    s.mult = m;
    s.prediv = n;
    s.postdiv = o;
    s.div0 = c0;
    s.div1 = c1;
    s.div2 = c2;
    s.phase1 = phase_one;
    s.out_en = 3'h7;
    @(negedge CORE_CLK);
    PLL_RESET_LOW = 1'b0;
    PLL_SETTINGS = s;
    REFERENCE_SELECT = sel;
    repeat (3) @(negedge CORE_CLK);
    check("lock in pll reset", LOCKED, 1'b0);
    check("clocks in pll reset", clks, 5'h00);
    PLL_RESET_LOW = 1'b1;
  endtask : apply

  task automatic wait_lock();
    for (int i = 0; i < 3000 && LOCKED !== 1'b1; i++) @(negedge CORE_CLK);
    if (LOCKED !== 1'b1) begin
      n_errors++;
      $display("[FAIL] lock expected 1 seen %0b", LOCKED);
    end else begin
      // let the output accumulators get going
      repeat (4) @(negedge CORE_CLK);
    end
  endtask : wait_lock

  // cycles between two rising edges of one observed clock
  task automatic measure(string what, int idx, int exp);
    logic prev;
    int   n;
    int   rises;
    prev = clks[idx];
    n = 0;
    rises = 0;
    for (int k = 0; k < 1000 && rises < 2; k++) begin
      @(negedge CORE_CLK);
      if (rises == 1) n++;
      if (prev === 1'b0 && clks[idx] === 1'b1) rises++;
      prev = clks[idx];
    end
    check(what, n, exp);
  endtask : measure

  // cycles from a rising edge of output one to the next rising edge of output zero
  task automatic lag(string what, int exp);
    logic p0;
    logic p1;
    int   n;
    int   st;
    p0 = clks[0];
    p1 = clks[1];
    n = 0;
    st = 0;
    for (int k = 0; k < 1000 && st < 2; k++) begin
      @(negedge CORE_CLK);
      if (st == 0 && p1 === 1'b0 && clks[1] === 1'b1) st = 1;
      if (st == 1 && p0 === 1'b0 && clks[0] === 1'b1) st = 2;
      else if (st == 1) n++;
      p0 = clks[0];
      p1 = clks[1];
    end
    check(what, n, exp);
  endtask : lag

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_reset_hold();
    repeat (400) @(negedge CORE_CLK);
    check("lock while held", LOCKED, 1'b0);
    check("clocks while held", clks, 5'h00);
    $display("done reset hold");
  endtask : t_reset_hold

  task automatic t_internal();
    apply(PFI_FB_INTERNAL, PFI_SRC_PAD, 2'h0, 8'h04, 4'h2, 4'h2, 9'h004, 9'h002, 9'h008);
    wait_lock();
    check("lock", LOCKED, 1'b1);
    measure("out0 internal", 0, 128);
    measure("out1 internal", 1, 64);
    measure("out2 internal", 2, 256);
    measure("pfd internal", 3, 64);
    measure("post internal", 4, 32);
    $display("done internal feedback");
  endtask : t_internal

  // m*o*c0 = 8, inside the limit
  task automatic t_local();
    apply(PFI_FB_LOCAL, PFI_SRC_PAD, 2'h0, 8'h02, 4'h1, 4'h2, 9'h002, 9'h004, 9'h008);
    wait_lock();
    measure("out0 local", 0, 16);
    measure("out1 local", 1, 32);
    measure("out2 local", 2, 64);
    measure("post local", 4, 8);
    $display("done local feedback");
  endtask : t_local

  // core source is input one, period 40
  task automatic t_core();
    apply(PFI_FB_CORE, PFI_SRC_CORE, 2'h0, 8'h02, 4'h1, 4'h2, 9'h002, 9'h004, 9'h008);
    wait_lock();
    measure("pfd core source", 3, 40);
    measure("out0 core fb", 0, 20);
    measure("out1 core fb", 1, 40);
    $display("done core feedback");
  endtask : t_core

  task automatic t_dynamic();
    for (int s = 3; s >= 0; s--) begin
      apply(PFI_FB_INTERNAL, PFI_SRC_DYNAMIC, 2'(s), 8'h02, 4'h1, 4'h2, 9'h002, 9'h002, 9'h002);
      wait_lock();
      measure("pfd dynamic", 3, 32 + 8 * s);
    end
    $display("done dynamic select");
  endtask : t_dynamic

  task automatic t_refused();
    apply(PFI_FB_LOCAL, PFI_SRC_PAD, 2'h0, 8'hff, 4'h1, 4'h2, 9'h002, 9'h002, 9'h002);
    repeat (2) @(negedge CORE_CLK);
    check("product over limit", SETTING_ERROR, 1'b1);
    repeat (600) @(negedge CORE_CLK);
    check("no lock when refused", LOCKED, 1'b0);
    apply(PFI_FB_INTERNAL, PFI_SRC_PAD, 2'h0, 8'h02, 4'h1, 4'h1, 9'h002, 9'h002, 9'h002);
    repeat (2) @(negedge CORE_CLK);
    check("post div one, three outs", SETTING_ERROR, 1'b1);
    $display("done refused settings");
  endtask : t_refused

  task automatic t_lock_loss();
    apply(PFI_FB_INTERNAL, PFI_SRC_PAD, 2'h0, 8'h02, 4'h1, 4'h2, 9'h002, 9'h002, 9'h002);
    wait_lock();
    check("settings accepted", SETTING_ERROR, 1'b0);
    stretch = 8'h04;
    for (int i = 0; i < 400 && LOCKED !== 1'b0; i++) @(negedge CORE_CLK);
    check("lock lost", LOCKED, 1'b0);
    wait_lock();
    // long enough for the gap counter to saturate
    stop = 1'b1;
    repeat (65600) @(negedge CORE_CLK);
    check("lock kept on dead ref", LOCKED, 1'b1);
    stop = 1'b0;
    stretch = 8'h00;
    $display("done lock loss");
  endtask : t_lock_loss

  // 90 leads output one by a quarter of its 64-cycle period; 45 is not allowed at c of 2
  task automatic t_phase();
    phase_one = 3'h2;
    apply(PFI_FB_INTERNAL, PFI_SRC_PAD, 2'h0, 8'h02, 4'h1, 4'h2, 9'h002, 9'h002, 9'h002);
    wait_lock();
    lag("out1 lead at 90", 16);
    phase_one = 3'h1;
    apply(PFI_FB_INTERNAL, PFI_SRC_PAD, 2'h0, 8'h02, 4'h1, 4'h2, 9'h002, 9'h002, 9'h002);
    wait_lock();
    lag("out1 lead at refused 45", 0);
    phase_one = 3'h0;
    $display("done phase shift");
  endtask : t_phase

  initial begin
    CORE_CLK = 1'b0;
    RESETN = 1'b0;
    PLL_RESET_LOW = 1'b0;
    REFERENCE_SELECT = 2'h0;
    PLL_SETTINGS = '0;
    stop = 1'b0;
    stretch = 8'h00;
    phase_one = 3'h0;
    n_errors = 0;
    checked = 0;
    repeat (6) @(negedge CORE_CLK);
    RESETN = 1'b1;
    t_reset_hold();
    t_internal();
    t_local();
    t_core();
    t_dynamic();
    t_refused();
    t_phase();
    t_lock_loss();
    report_and_stop();
  end
endmodule : tb_pll_fabric_interface
